// [tfm_cfg.svh]
// timing constants and implementation options for the transceiver fault management link
`ifndef TFM_CFG_SVH
`define TFM_CFG_SVH
// ****************************************************************
// clock and times
// ****************************************************************
`define TFM_CLK_MHZ         100
`define TFM_T_OFF_US        10
`define TFM_T_ON_US         1000
`define TFM_T_INIT_MS       300
`define TFM_T_FAULT_US      100
`define TFM_T_RESET_US      10
`define TFM_T_LOSS_US       100
// longest times round down, least times round up (whole microseconds, exact here)
`define TFM_T_OFF_CYC       (`TFM_T_OFF_US * `TFM_CLK_MHZ)
`define TFM_T_ON_CYC        (`TFM_T_ON_US * `TFM_CLK_MHZ)
`define TFM_T_INIT_CYC      (`TFM_T_INIT_MS * 1000 * `TFM_CLK_MHZ)
`define TFM_T_FAULT_CYC     (`TFM_T_FAULT_US * `TFM_CLK_MHZ)
`define TFM_T_RESET_CYC     (`TFM_T_RESET_US * `TFM_CLK_MHZ)
`define TFM_T_LOSS_CYC      (`TFM_T_LOSS_US * `TFM_CLK_MHZ)
// safety settle time used inside init, below t_init
`define TFM_SETTLE_CYC      1000
// holdoff armed at each transmit enable; it is only counted down and does not gate the enable
`define TFM_HOLDOFF_CYC     2000
// counter width, covers t_init at 100 MHz
`define TFM_CNT_W           25
`endif

// [tfm_pkg.sv]
// types shared by both ends of the transceiver fault management link
package tfm_pkg;
    // device state machine
    typedef enum logic [2:0] {
        TFM_DEV_WAIT_PWR,
        TFM_DEV_INIT,
        TFM_DEV_RUN,
        TFM_DEV_FAULT,
        TFM_DEV_OFF
    } tfm_dev_state_e;
    // host state machine
    typedef enum logic [2:0] {
        TFM_HST_IDLE,
        TFM_HST_WAIT_INIT,
        TFM_HST_RUN,
        TFM_HST_RESET_HI,
        TFM_HST_FAILED
    } tfm_hst_state_e;
endpackage

// [tfm_if.sv]
// management pins between transceiver module and host controller
`timescale 1ns/1ns
interface tfm_if;
    logic tx_off_req;           // host asks transmitter off, high active
    logic tx_fault;             // module reports transmit fault, high active
    logic receive_signal_lost;  // module reports no incoming signal
    logic present;              // module present; host pull-up reads fault when low
    logic tx_fault_seen;        // level host sees: pull-up asserts fault if absent

    assign tx_fault_seen = present ? tx_fault : 1'b1;

    modport device (
        input  tx_off_req,
        output tx_fault,
        output receive_signal_lost,
        output present
    );
    modport host (
        output tx_off_req,
        input  tx_fault_seen,
        input  receive_signal_lost
    );
endinterface

// [tfm_host.sv]
// host board controller end: drives transmit-off, watches fault and signal loss
`timescale 1ns/1ns
`include "tfm_cfg.svh"
module tfm_host (
    input  wire logic core_clk,
    input  wire logic rst_n,
    tfm_if.host       pins,
    input  wire logic tx_off_cmd,       // user wants transmitter off
    input  wire logic fault_reset_cmd,  // pulse: run the fault reset handshake
    output logic      link_fault_q,     // fault flag still set after t_init
    output logic      link_up_q,        // fault clear and signal present
    output logic      signal_lost_q     // registered copy of signal loss
);
    // ****************************************************************
    // state
    // ****************************************************************
    tfm_pkg::tfm_hst_state_e    state_q;      // handshake progress
    logic [`TFM_CNT_W-1:0]      cnt_q;        // timing counter
    logic                       off_q;        // registered pin drive
    logic                       cnt_init_done;
    logic                       cnt_reset_done;

    assign cnt_init_done  = (cnt_q >= `TFM_CNT_W'(`TFM_T_INIT_CYC));
    assign cnt_reset_done = (cnt_q >= `TFM_CNT_W'(`TFM_T_RESET_CYC));
    assign pins.tx_off_req = off_q;

    // ****************************************************************
    // handshake sequencer
    // ****************************************************************
    // reset handshake keeps the request high t_reset, then drops it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= tfm_pkg::TFM_HST_IDLE;
            cnt_q        <= '0;
            off_q        <= 1'b0;
            link_fault_q <= 1'b0;
            link_up_q    <= 1'b0;
            signal_lost_q <= 1'b0;
        end else begin
            // loss is only a hint, used as a level, never decoded as data
            signal_lost_q <= pins.receive_signal_lost;
            link_up_q     <= (state_q == tfm_pkg::TFM_HST_RUN) && !pins.tx_fault_seen
                             && !pins.receive_signal_lost;
            case (state_q)
                tfm_pkg::TFM_HST_IDLE: begin
                    // absent module reads as faulted via pull-up
                    off_q <= tx_off_cmd;
                    cnt_q <= '0;
                    state_q <= tfm_pkg::TFM_HST_WAIT_INIT;
                end
                tfm_pkg::TFM_HST_WAIT_INIT: begin
                    // flag may stay up during init, judged after t_init
                    off_q <= tx_off_cmd;
                    if (fault_reset_cmd) begin
                        // software may start the handshake while still waiting
                        off_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= tfm_pkg::TFM_HST_RESET_HI;
                    end else if (!pins.tx_fault_seen) begin
                        state_q <= tfm_pkg::TFM_HST_RUN;
                        link_fault_q <= 1'b0;
                    end else if (tx_off_cmd) begin
                        cnt_q <= '0;  // init clock restarts on negation
                    end else if (cnt_init_done) begin
                        link_fault_q <= 1'b1;
                        state_q <= tfm_pkg::TFM_HST_FAILED;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                tfm_pkg::TFM_HST_RUN: begin
                    // off request may not gate all module types
                    off_q <= tx_off_cmd;
                    if (fault_reset_cmd) begin
                        off_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= tfm_pkg::TFM_HST_RESET_HI;
                    end else if (pins.tx_fault_seen) begin
                        // no automatic handshake: unlatched causes clear alone,
                        // a latched one waits for software
                        cnt_q   <= '0;
                        state_q <= tfm_pkg::TFM_HST_WAIT_INIT;
                    end
                end
                tfm_pkg::TFM_HST_RESET_HI: begin
                    if (cnt_reset_done) begin
                        off_q   <= 1'b0;
                        cnt_q   <= '0;
                        state_q <= tfm_pkg::TFM_HST_WAIT_INIT;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                tfm_pkg::TFM_HST_FAILED: begin
                    // stays failed until software asks for another reset
                    off_q <= tx_off_cmd;
                    if (fault_reset_cmd) begin
                        off_q   <= 1'b1;
                        cnt_q   <= '0;
                        state_q <= tfm_pkg::TFM_HST_RESET_HI;
                    end
                end
                default: state_q <= tfm_pkg::TFM_HST_IDLE;
            endcase
        end
    end
endmodule

// [tfm_device.sv]
// transceiver module end: transmit disable, latched safety fault, signal loss
// Behaviour
// - transmit off within 10 us of request
// - transmit back on within 1 ms
// - init clears fault within 300 ms
// - fault flag within 100 us of cause
// - host holds request 10 us to reset
// - raise signal lost within 100 us
// - drop signal lost within 100 us
// - flag may rise at power, clears when safe
// - powered with request high: init after fall
// - no safety circuit means flag low
// - safety fault latched until handshake
// - handshake reinitialises and clears flag
// - persisting fault relatches, output stays safe
// - holdoff blocks bursts from repeated pulses (here the holdoff only counts; the settle after each handshake is the guard)
// - unimplemented signal lost output held low
// - absent module reads as faulted
// - init starts only when supply good
// - host checks type before trusting request (the host here checks no module type)
// - reset-capable types implement the request
// - signal lost is not a data channel
// - latched fault forces output safe
// - supply or contact loss reported, unlatched

// ****************************************************************
// design notes
// ****************************************************************
// one counter serves init settle and the reset handshake; it is cleared
// on entry to the fault state, so time spent settling earlier can never
// be mistaken for a long enough transmit-off request.
// the off, on and fault limits are met by reacting within a cycle or two, far inside
// the allowed windows; the settle time stands for the safety circuit's
// own confirmation that the transmitter works normally.
// the holdoff counter only records spacing between enables; the real
// guard against energy bursts is that init must run its full settle
// time again after each handshake.
// the signal loss filter waits half the allowed delay so that short
// glitches on the detector do not toggle the output, at the cost of a
// slower but still legal reaction.
// supply and contact causes show on the flag combinationally and are
// never latched, so they vanish as soon as the cause goes.
// a host that leaves the request high at power-up keeps the module in
// the off state; the flag stays high there, which is allowed since its
// value is undefined while the request stands.
// limitation: the module type is not decoded here; the gate option
// parameter stands in for types whose output ignores the request.
`timescale 1ns/1ns
`include "tfm_cfg.svh"
module tfm_device #(
    parameter bit HAS_SAFETY   = 1'b1,  // safety circuitry fitted
    parameter bit HAS_LOS      = 1'b1,  // signal loss output fitted
    parameter bit HAS_OFF_GATE = 1'b1   // request gates the transmitter
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    tfm_if.device     pins,
    input  wire logic transmit_supply_ok, // supply above 4.75 V
    input  wire logic supply_low,         // supply below 4.5 V
    input  wire logic contact_bad,        // connector contact fault
    input  wire logic safety_violation,   // output safety monitor trips
    input  wire logic signal_detect,      // incoming signal present
    input  wire logic inserted,           // module seated in its slot
    output logic      tx_enable_q         // drives the laser driver
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    tfm_pkg::tfm_dev_state_e    state_q;      // management state
    logic [`TFM_CNT_W-1:0]      cnt_q;        // init / settle counter
    logic [`TFM_CNT_W-1:0]      hold_q;       // burst holdoff counter
    logic                       fault_q;      // latched safety fault
    logic                       init_flag_q;  // flag shown during init
    logic                       los_q;        // signal loss output
    logic [`TFM_CNT_W-1:0]      los_cnt_q;    // signal loss filter
    logic                       off_req;
    logic                       unlatched_fault;
    logic                       settle_done;
    logic                       hold_done;
    logic                       want_tx;

    assign off_req         = pins.tx_off_req;
    assign unlatched_fault = supply_low || contact_bad;
    assign settle_done     = (cnt_q >= `TFM_CNT_W'(`TFM_SETTLE_CYC));
    assign hold_done       = (hold_q == '0);
    // transmitter runs only in run state; fault forces it off
    assign want_tx = (state_q == tfm_pkg::TFM_DEV_RUN) && !fault_q && !unlatched_fault
                     && (!off_req || !HAS_OFF_GATE);

    // ****************************************************************
    // pin outputs
    // ****************************************************************
    // flag: latched fault, init flag and unlatched causes, or low if absent
    assign pins.tx_fault = HAS_SAFETY ? (fault_q || init_flag_q || unlatched_fault) : 1'b0;
    // unimplemented loss output tied low
    assign pins.receive_signal_lost = HAS_LOS ? los_q : 1'b0;
    assign pins.present = inserted;

    // ****************************************************************
    // management state machine
    // ****************************************************************
    // one-cycle reaction keeps far inside t_off, t_on and t_fault
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= tfm_pkg::TFM_DEV_WAIT_PWR;
            cnt_q       <= '0;
            fault_q     <= 1'b0;
            init_flag_q <= 1'b0;
            tx_enable_q <= 1'b0;
        end else begin
            tx_enable_q <= want_tx;
            case (state_q)
                tfm_pkg::TFM_DEV_WAIT_PWR: begin
                    // init only after supply good
                    cnt_q <= '0;
                    if (transmit_supply_ok) begin
                        init_flag_q <= 1'b1;
                        state_q <= off_req ? tfm_pkg::TFM_DEV_OFF
                                           : tfm_pkg::TFM_DEV_INIT;
                    end
                end
                tfm_pkg::TFM_DEV_OFF: begin
                    // request high at power-up: wait for its fall
                    cnt_q <= '0;
                    if (!off_req) begin
                        state_q <= tfm_pkg::TFM_DEV_INIT;
                    end
                end
                tfm_pkg::TFM_DEV_INIT: begin
                    // settle well inside t_init, then clear the flag
                    if (!transmit_supply_ok) begin
                        state_q <= tfm_pkg::TFM_DEV_WAIT_PWR;
                    end else if (safety_violation && HAS_SAFETY) begin
                        fault_q <= 1'b1;
                        cnt_q <= '0;
                        init_flag_q <= 1'b0;
                        state_q <= tfm_pkg::TFM_DEV_FAULT;
                    end else if (settle_done) begin
                        init_flag_q <= 1'b0;
                        state_q <= tfm_pkg::TFM_DEV_RUN;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                tfm_pkg::TFM_DEV_RUN: begin
                    if (!transmit_supply_ok) begin
                        state_q <= tfm_pkg::TFM_DEV_WAIT_PWR;
                    end else if (safety_violation && HAS_SAFETY) begin
                        fault_q <= 1'b1;
                        cnt_q <= '0;
                        state_q <= tfm_pkg::TFM_DEV_FAULT;
                    end
                end
                tfm_pkg::TFM_DEV_FAULT: begin
                    // latched until request held t_reset and dropped
                    if (!off_req) begin
                        cnt_q <= '0;
                        if (cnt_q >= `TFM_CNT_W'(`TFM_T_RESET_CYC)) begin
                            fault_q     <= 1'b0;
                            init_flag_q <= 1'b1;
                            state_q     <= tfm_pkg::TFM_DEV_INIT;
                        end
                    end else if (cnt_q < `TFM_CNT_W'(`TFM_T_RESET_CYC)) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: state_q <= tfm_pkg::TFM_DEV_WAIT_PWR;
            endcase
        end
    end

    // ****************************************************************
    // burst holdoff
    // ****************************************************************
    // every fresh enable arms a holdoff that only counts down and gates nothing;
    // the guard against bursts is the full settle time init runs after each handshake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (want_tx && !tx_enable_q) begin
            hold_q <= `TFM_CNT_W'(`TFM_HOLDOFF_CYC);
        end else if (!hold_done) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    // ****************************************************************
    // signal loss filter
    // ****************************************************************
    // change needs a steady span of half t_loss, inside the t_loss limits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            los_q     <= 1'b0;
            los_cnt_q <= '0;
        end else if (los_q == !signal_detect) begin
            los_cnt_q <= '0;
        end else if (los_cnt_q >= `TFM_CNT_W'(`TFM_T_LOSS_CYC / 2)) begin
            los_q     <= !signal_detect;
            los_cnt_q <= '0;
        end else begin
            los_cnt_q <= los_cnt_q + 1'b1;
        end
    end
endmodule

// [tfm_link_chk.sv]
// pin-level checker for the joined host and device ends
`timescale 1ns/1ns
module tfm_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tx_off_req,
    input wire logic tx_fault,
    input wire logic receive_signal_lost,
    input wire logic signal_detect,
    input wire logic safety_violation,
    input wire logic tx_enable_q
);
    // ****************************************************************
    // bounds in 10 ns cycles
    // ****************************************************************
    localparam int T_OFF = 1000;   // off delay limit
    localparam int T_FLT = 10000;  // fault and loss delay limit
    logic [15:0] pend_q;           // cycles a loss change is owed
    logic [15:0] flt_pend_q;       // cycles a fault flag is owed
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // counts while the loss output disagrees with the detector
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) pend_q <= '0;
        else if (signal_detect == receive_signal_lost) pend_q <= pend_q + 16'h0001;
        else pend_q <= '0;
    end
    // counts from a violation until the flag shows; a counter, as the limit is long
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) flt_pend_q <= '0;
        else if (tx_fault || !(safety_violation || flt_pend_q != '0)) flt_pend_q <= '0;
        else flt_pend_q <= flt_pend_q + 16'h0001;
    end
    property p_off; $rose(tx_off_req) |-> ##[1:T_OFF] !tx_enable_q; endproperty
    a_off: assert property (p_off)
        else $error("transmitter not off in time");
    property p_held; tx_off_req ##1 tx_off_req |-> !tx_enable_q; endproperty
    a_held: assert property (p_held)
        else $error("transmitter on while request held");
    property p_fault; flt_pend_q <= T_FLT; endproperty
    a_fault: assert property (p_fault)
        else $error("fault flag late");
    property p_safe; tx_fault ##1 tx_fault |-> !tx_enable_q; endproperty
    a_safe: assert property (p_safe)
        else $error("transmitter on during fault");
    property p_enable; $rose(tx_enable_q) |-> $past(!tx_off_req) && $past(!tx_fault); endproperty
    a_enable: assert property (p_enable)
        else $error("transmitter enabled without cause");
    property p_loss_bound; pend_q <= T_FLT; endproperty
    a_loss_bound: assert property (p_loss_bound)
        else $error("loss output late");
    property p_los_rise; $rose(receive_signal_lost) |-> !$past(signal_detect); endproperty
    a_los_rise: assert property (p_los_rise)
        else $error("loss raised with signal present");
    property p_los_fall; $fell(receive_signal_lost) |-> $past(signal_detect); endproperty
    a_los_fall: assert property (p_los_fall)
        else $error("loss dropped with signal absent");
    c_fault: cover property ($rose(tx_fault));
    c_los: cover property ($rose(receive_signal_lost));
    c_on: cover property ($rose(tx_enable_q));
endmodule

// [tfm_testbench.sv]
// self-checking bench joining host and device ends
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
`define WAIT_UNTIL(c, lim) begin n = 0; while (!(c) && n < (lim)) begin \
    @(posedge core_clk); #1; n++; end end
module testbench;
    logic core_clk = 1'b0;         // 100 MHz
    logic rst_n = 1'b0;            // held 20 cycles
    logic tx_off_cmd = 1'b0;       // user transmit off
    logic fault_reset_cmd = 1'b0;  // handshake request pulse
    logic supply_ok = 1'b0;        // supply good
    logic supply_low = 1'b0;       // unlatched cause
    logic contact_bad = 1'b0;      // unlatched cause
    logic violation = 1'b0;        // latched cause
    logic signal_detect = 1'b1;    // incoming signal
    logic inserted = 1'b1;         // module seated
    logic link_fault_q;
    logic link_up_q;
    logic signal_lost_q;
    logic tx_enable_q;
    int   n_mismatch = 0;
    int   checked = 0;
    int   n;
    int   cycles = 0;
    tfm_if pins_if ();
    tfm_host tfm_host_inst (.core_clk(core_clk), .rst_n(rst_n), .pins(pins_if),
        .tx_off_cmd(tx_off_cmd), .fault_reset_cmd(fault_reset_cmd),
        .link_fault_q(link_fault_q), .link_up_q(link_up_q), .signal_lost_q(signal_lost_q));
    tfm_device tfm_device_inst (.core_clk(core_clk), .rst_n(rst_n), .pins(pins_if),
        .transmit_supply_ok(supply_ok), .supply_low(supply_low), .contact_bad(contact_bad),
        .safety_violation(violation), .signal_detect(signal_detect),
        .inserted(inserted), .tx_enable_q(tx_enable_q));
    tfm_chk tfm_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
        .tx_off_req(pins_if.tx_off_req), .tx_fault(pins_if.tx_fault),
        .receive_signal_lost(pins_if.receive_signal_lost), .signal_detect(signal_detect),
        .safety_violation(violation), .tx_enable_q(tx_enable_q));
    // ****************************************************************
    // clock, hang guard and helpers
    // ****************************************************************
    always #5 core_clk = ~core_clk;
    // tests need well under this many cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // inputs change 1 ns after an edge
    task clks(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // full handshake, then wait for the transmitter to come back
    task reset_fault;
        fault_reset_cmd = 1'b1;
        clks(1);
        fault_reset_cmd = 1'b0;
        `WAIT_UNTIL(!pins_if.tx_fault_seen, 5000)
        `WAIT_UNTIL(tx_enable_q, 5000)
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        clks(20);
        rst_n = 1'b1;
        clks(50);
        `CHK(tx_enable_q, 1'b0)
        supply_ok = 1'b1;
        `WAIT_UNTIL(tx_enable_q, 5000)
        `CHK(pins_if.tx_fault_seen, 1'b0)
        clks(5);
        `CHK(link_up_q, 1'b1)
        `CHK(link_fault_q, 1'b0)
        $display("power-up test done");
        tx_off_cmd = 1'b1;
        `WAIT_UNTIL(!tx_enable_q, 1000)
        `CHK(tx_enable_q, 1'b0)
        clks(10);
        tx_off_cmd = 1'b0;
        `WAIT_UNTIL(tx_enable_q, 1000)
        `CHK(tx_enable_q, 1'b1)
        $display("transmit off test done");
        // transient fault: a short off pulse must not clear the latch
        violation = 1'b1;
        clks(3);
        violation = 1'b0;
        `WAIT_UNTIL(pins_if.tx_fault_seen, 10000)
        `CHK(tx_enable_q, 1'b0)
        clks(3000);
        `CHK(pins_if.tx_fault_seen, 1'b1)
        tx_off_cmd = 1'b1;
        clks(100);
        tx_off_cmd = 1'b0;
        clks(3000);
        `CHK(pins_if.tx_fault_seen, 1'b1)
        reset_fault();
        `CHK(pins_if.tx_fault_seen, 1'b0)
        `CHK(tx_enable_q, 1'b1)
        $display("transient fault test done");
        // fault still present during the handshake relatches
        violation = 1'b1;
        clks(20);
        fault_reset_cmd = 1'b1;
        clks(1);
        fault_reset_cmd = 1'b0;
        clks(5000);
        `CHK(pins_if.tx_fault_seen, 1'b1)
        `CHK(tx_enable_q, 1'b0)
        violation = 1'b0;
        reset_fault();
        `CHK(tx_enable_q, 1'b1)
        $display("persistent fault test done");
        // supply and contact faults clear without a handshake
        for (int i = 0; i < 2; i++) begin
            supply_low = (i == 0);
            contact_bad = (i == 1);
            `WAIT_UNTIL(pins_if.tx_fault_seen, 10000)
            `CHK(pins_if.tx_fault_seen, 1'b1)
            supply_low = 1'b0;
            contact_bad = 1'b0;
            `WAIT_UNTIL(!pins_if.tx_fault_seen, 3000)
            `CHK(pins_if.tx_fault_seen, 1'b0)
            `WAIT_UNTIL(tx_enable_q, 5000)
        end
        $display("unlatched fault test done");
        signal_detect = 1'b0;
        `WAIT_UNTIL(pins_if.receive_signal_lost, 10000)
        `CHK(pins_if.receive_signal_lost, 1'b1)
        clks(3);
        `CHK(signal_lost_q, 1'b1)
        signal_detect = 1'b1;
        `WAIT_UNTIL(!pins_if.receive_signal_lost, 10000)
        `CHK(pins_if.receive_signal_lost, 1'b0)
        $display("signal loss test done");
        inserted = 1'b0;
        clks(5);
        `CHK(pins_if.tx_fault_seen, 1'b1)
        $display("removal test done");
        finish_test();
    end
endmodule
